/* ims_pkg.sv */
// shared constants and types for the indirect move and return execution unit
package ims_pkg;

    // ----------------------------------------------------------------
    // widths
    // ----------------------------------------------------------------
    localparam int unsigned ADDR_W = 8;
    localparam int unsigned DATA_W = 32;
    localparam int unsigned INSTR_W = 14;
    localparam int unsigned PC_W = 15;
    localparam int unsigned FSR_W = 16;
    localparam int unsigned MEM_AW = 5;
    localparam int unsigned STK_AW = 4;
    localparam int unsigned STK_DEPTH = 16;

    // ----------------------------------------------------------------
    // register byte offsets
    // ----------------------------------------------------------------
    localparam logic [ADDR_W-1:0] OFF_INSTR = 8'h00;
    localparam logic [ADDR_W-1:0] OFF_STAT = 8'h04;
    localparam logic [ADDR_W-1:0] OFF_WREG = 8'h08;
    localparam logic [ADDR_W-1:0] OFF_FSR0 = 8'h0c;
    localparam logic [ADDR_W-1:0] OFF_FSR1 = 8'h10;
    localparam logic [ADDR_W-1:0] OFF_PC = 8'h14;
    localparam logic [ADDR_W-1:0] OFF_ICTL = 8'h18;
    localparam logic [ADDR_W-1:0] OFF_PCTL = 8'h1c;
    localparam logic [ADDR_W-1:0] OFF_STACK = 8'h20;
    localparam logic [ADDR_W-1:0] OFF_INDF0 = 8'h24;
    localparam logic [ADDR_W-1:0] OFF_INDF1 = 8'h28;

    // ----------------------------------------------------------------
    // field positions and reset values
    // ----------------------------------------------------------------
    localparam int unsigned IEN_BIT = 7;
    localparam int unsigned SWRF_BIT = 2;
    localparam int unsigned STAT_BUSY_BIT = 0;
    localparam int unsigned STAT_SP_LSB = 8;
    localparam int unsigned STAT_CNT_LSB = 16;
    localparam logic [7:0] RST_W = 8'h00;
    localparam logic [FSR_W-1:0] RST_FSR = 16'h0000;
    localparam logic [PC_W-1:0] RST_PC = 15'h0000;
    localparam logic RST_IEN = 1'b0;
    localparam logic RST_SWRF = 1'b1;

    // ----------------------------------------------------------------
    // instruction encodings
    // ----------------------------------------------------------------
    localparam logic [INSTR_W-1:0] OPC_NOP = 14'h0000;
    localparam logic [INSTR_W-1:0] OPC_RESET = 14'h0001;
    localparam logic [INSTR_W-1:0] OPC_RETI = 14'h0009;
    localparam logic [INSTR_W-1:0] MSK_STWI = 14'h3ff8;
    localparam logic [INSTR_W-1:0] OPC_STWI = 14'h0018;
    localparam logic [INSTR_W-1:0] MSK_STWI_K = 14'h3f80;
    localparam logic [INSTR_W-1:0] OPC_STWI_K = 14'h3f80;
    localparam logic [INSTR_W-1:0] MSK_RETK = 14'h3f00;
    localparam logic [INSTR_W-1:0] OPC_RETK = 14'h3400;

    localparam logic [1:0] RESP_OKAY = 2'b00;
    localparam logic [1:0] RESP_SLVERR = 2'b10;

    // ----------------------------------------------------------------
    // types
    // ----------------------------------------------------------------
    typedef enum logic [2:0] {
        OP_NOP,
        OP_STWI,
        OP_STWI_K,
        OP_RESET,
        OP_RETI,
        OP_RETK
    } ims_op_t;

    typedef enum logic [1:0] {
        MODE_PREINC = 2'b00,
        MODE_PREDEC = 2'b01,
        MODE_POSTINC = 2'b10,
        MODE_POSTDEC = 2'b11
    } ims_mode_t;

    typedef enum logic [2:0] {
        ST_IDLE = 3'b001,
        ST_EXEC = 3'b010,
        ST_HOLD = 3'b100
    } ims_state_t;

    typedef struct packed {
        ims_op_t op;
        logic fsr_sel;
        ims_mode_t mode;
        logic [5:0] offset;
        logic [7:0] literal;
    } ims_dec_t;

    typedef struct packed {
        logic we;
        logic [MEM_AW-1:0] addr;
        logic [7:0] data;
    } ims_wr_t;

endpackage

/* ims_data_ram.sv */
// flip-flop data memory reached only through the file select pointers
module ims_data_ram (
    input wire logic clk,
    input wire logic rst_n,
    input wire ims_pkg::ims_wr_t wr,
    input wire logic [ims_pkg::MEM_AW-1:0] raddr0,
    input wire logic [ims_pkg::MEM_AW-1:0] raddr1,
    output logic [7:0] rdata0,
    output logic [7:0] rdata1
);

    localparam int unsigned DEPTH = 1 << ims_pkg::MEM_AW;

    logic [7:0] mem_q [DEPTH];

    // ----------------------------------------------------------------
    // storage
    // ----------------------------------------------------------------
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            for (int i = 0; i < DEPTH; i++) begin
                mem_q[i] <= 8'h00;
            end
        end else if (wr.we) begin
            mem_q[wr.addr] <= wr.data;
        end
    end

    assign rdata0 = mem_q[raddr0];
    assign rdata1 = mem_q[raddr1];

endmodule

/* ims_exec_unit.sv */
// execution unit for indirect store, no-operation, software reset and returns
//
// What this block does
// - indirect store address is pointer plus one or minus one (pre modes), pointer itself (post modes), or plus signed offset
// - afterwards pointer is up one, down one, or unchanged for offset mode
// - mode code 00 preinc, 01 predec, 10 postinc, 11 postdec
// - window registers hold nothing; access reaches address held in matching pointer
// - software reset instruction starts a full device reset
// - software reset clears the reset instruction flag in power control
// - return from interrupt pops the stack top entry into program counter
// - return from interrupt sets global interrupt enable, bit 7 of interrupt control
// - return from interrupt is one word, two cycles, flags unchanged
// - return with literal loads the 8-bit literal into working register
// - return with literal pops stack into program counter, two cycles
// - indirect store copies working register through the window, flags unchanged
//
// The AXI4-Lite slave port and the address map were chosen for this implementation.
module ims_exec_unit (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic [7:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [7:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    output logic device_reset_req,
    output logic global_interrupt_enable,
    output logic busy
);

    // ----------------------------------------------------------------
    // helpers
    // ----------------------------------------------------------------
    // pointer after a pre or post step
    function automatic logic [ims_pkg::FSR_W-1:0] ptr_step(
        input logic [ims_pkg::FSR_W-1:0] ptr,
        input ims_pkg::ims_mode_t mode
    );
        logic [ims_pkg::FSR_W-1:0] r;
        r = ptr;
        unique case (mode)
            ims_pkg::MODE_PREINC, ims_pkg::MODE_POSTINC: r = ptr + 16'h0001;
            ims_pkg::MODE_PREDEC, ims_pkg::MODE_POSTDEC: r = ptr - 16'h0001;
        endcase
        return r;
    endfunction

    // data memory index for a pointer value
    function automatic logic [ims_pkg::MEM_AW-1:0] mem_idx(
        input logic [ims_pkg::FSR_W-1:0] ptr
    );
        return ptr[ims_pkg::MEM_AW-1:0];
    endfunction

    // ----------------------------------------------------------------
    // state
    // ----------------------------------------------------------------
    ims_pkg::ims_state_t state_q, state_d;
    logic [ims_pkg::INSTR_W-1:0] ins_q;
    logic [7:0] w_q, w_d;
    logic [ims_pkg::FSR_W-1:0] fsr0_q, fsr0_d;
    logic [ims_pkg::FSR_W-1:0] fsr1_q, fsr1_d;
    logic [ims_pkg::PC_W-1:0] pc_q, pc_d;
    logic ien_q, ien_d;
    logic swrf_q, swrf_d;
    logic [ims_pkg::PC_W-1:0] stk_q [ims_pkg::STK_DEPTH];
    logic [ims_pkg::STK_AW-1:0] sp_q, sp_d;
    logic [ims_pkg::STK_AW:0] cnt_q, cnt_d;
    logic rst_req_q;

    // ----------------------------------------------------------------
    // axi4-lite write side
    // ----------------------------------------------------------------
    logic aw_full_q, w_full_q, bvalid_q;
    logic [7:0] aw_addr_q;
    logic [31:0] w_data_q;
    logic [3:0] w_strb_q;
    logic [1:0] bresp_q;

    wire aw_take = s_axi_awvalid && s_axi_awready;
    wire w_take = s_axi_wvalid && s_axi_wready;
    wire wr_fire = aw_full_q && w_full_q && !bvalid_q && (state_q == ims_pkg::ST_IDLE);
    wire lo_en = w_strb_q[0];
    wire wa_instr = wr_fire && aw_addr_q == ims_pkg::OFF_INSTR;
    wire wa_wreg = wr_fire && lo_en && aw_addr_q == ims_pkg::OFF_WREG;
    wire wa_fsr0 = wr_fire && aw_addr_q == ims_pkg::OFF_FSR0;
    wire wa_fsr1 = wr_fire && aw_addr_q == ims_pkg::OFF_FSR1;
    wire wa_pc = wr_fire && aw_addr_q == ims_pkg::OFF_PC;
    wire wa_ictl = wr_fire && lo_en && aw_addr_q == ims_pkg::OFF_ICTL;
    wire wa_pctl = wr_fire && lo_en && aw_addr_q == ims_pkg::OFF_PCTL;
    wire wa_stack = wr_fire && aw_addr_q == ims_pkg::OFF_STACK;
    wire wa_indf0 = wr_fire && lo_en && aw_addr_q == ims_pkg::OFF_INDF0;
    wire wa_indf1 = wr_fire && lo_en && aw_addr_q == ims_pkg::OFF_INDF1;
    wire wa_known = aw_addr_q == ims_pkg::OFF_INSTR || aw_addr_q == ims_pkg::OFF_STAT
        || aw_addr_q == ims_pkg::OFF_WREG || aw_addr_q == ims_pkg::OFF_FSR0
        || aw_addr_q == ims_pkg::OFF_FSR1 || aw_addr_q == ims_pkg::OFF_PC
        || aw_addr_q == ims_pkg::OFF_ICTL || aw_addr_q == ims_pkg::OFF_PCTL
        || aw_addr_q == ims_pkg::OFF_STACK || aw_addr_q == ims_pkg::OFF_INDF0
        || aw_addr_q == ims_pkg::OFF_INDF1;

    assign s_axi_awready = !aw_full_q;
    assign s_axi_wready = !w_full_q;
    assign s_axi_bvalid = bvalid_q;
    assign s_axi_bresp = bresp_q;

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            aw_full_q <= 1'b0;
            w_full_q <= 1'b0;
            aw_addr_q <= 8'h00;
            w_data_q <= 32'h0000_0000;
            w_strb_q <= 4'h0;
        end else begin
            if (aw_take) begin
                aw_full_q <= 1'b1;
                aw_addr_q <= s_axi_awaddr;
            end else if (wr_fire) begin
                aw_full_q <= 1'b0;
            end
            if (w_take) begin
                w_full_q <= 1'b1;
                w_data_q <= s_axi_wdata;
                w_strb_q <= s_axi_wstrb;
            end else if (wr_fire) begin
                w_full_q <= 1'b0;
            end
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            bvalid_q <= 1'b0;
            bresp_q <= ims_pkg::RESP_OKAY;
        end else if (wr_fire) begin
            bvalid_q <= 1'b1;
            bresp_q <= wa_known ? ims_pkg::RESP_OKAY : ims_pkg::RESP_SLVERR;
        end else if (s_axi_bready) begin
            bvalid_q <= 1'b0;
        end
    end

    // ----------------------------------------------------------------
    // instruction decode
    // ----------------------------------------------------------------
    ims_pkg::ims_dec_t dec;
    wire is_stwi = (ins_q & ims_pkg::MSK_STWI) == ims_pkg::OPC_STWI;
    wire is_stwi_k = (ins_q & ims_pkg::MSK_STWI_K) == ims_pkg::OPC_STWI_K;
    wire is_retk = (ins_q & ims_pkg::MSK_RETK) == ims_pkg::OPC_RETK;

    assign dec.op = is_stwi ? ims_pkg::OP_STWI
        : is_stwi_k ? ims_pkg::OP_STWI_K
        : is_retk ? ims_pkg::OP_RETK
        : ins_q == ims_pkg::OPC_RESET ? ims_pkg::OP_RESET
        : ins_q == ims_pkg::OPC_RETI ? ims_pkg::OP_RETI
        : ims_pkg::OP_NOP;
    assign dec.fsr_sel = is_stwi ? ins_q[2] : ins_q[6];
    assign dec.mode = ims_pkg::ims_mode_t'(ins_q[1:0]);
    assign dec.offset = ins_q[5:0];
    assign dec.literal = ins_q[7:0];

    // ----------------------------------------------------------------
    // indirect store address
    // ----------------------------------------------------------------
    wire exec = state_q == ims_pkg::ST_EXEC;
    wire [ims_pkg::FSR_W-1:0] fsr_sel_v = dec.fsr_sel ? fsr1_q : fsr0_q;
    wire [ims_pkg::FSR_W-1:0] fsr_stepped = ptr_step(fsr_sel_v, dec.mode);
    wire is_pre = !dec.mode[1];
    wire [ims_pkg::FSR_W-1:0] koff = {{(ims_pkg::FSR_W-6){dec.offset[5]}}, dec.offset};
    wire [ims_pkg::FSR_W-1:0] ea = dec.op == ims_pkg::OP_STWI_K ? fsr_sel_v + koff
        : is_pre ? fsr_stepped : fsr_sel_v;
    wire do_store = exec && (dec.op == ims_pkg::OP_STWI || dec.op == ims_pkg::OP_STWI_K);
    wire do_pop = exec && (dec.op == ims_pkg::OP_RETI || dec.op == ims_pkg::OP_RETK);
    wire do_sreset = exec && dec.op == ims_pkg::OP_RESET;
    wire [ims_pkg::STK_AW-1:0] sp_top = sp_q - 4'h1;

    // window writes land at the pointed-to address; the store wins over none since
    // bus writes only fire while idle
    ims_pkg::ims_wr_t mem_wr;
    assign mem_wr.we = do_store || wa_indf0 || wa_indf1;
    assign mem_wr.addr = do_store ? mem_idx(ea)
        : wa_indf1 ? mem_idx(fsr1_q) : mem_idx(fsr0_q);
    assign mem_wr.data = do_store ? w_q : w_data_q[7:0];

    logic [7:0] indf0_data, indf1_data;

    ims_data_ram u_ram (
        .clk(clk),
        .rst_n(rst_n),
        .wr(mem_wr),
        .raddr0(mem_idx(fsr0_q)),
        .raddr1(mem_idx(fsr1_q)),
        .rdata0(indf0_data),
        .rdata1(indf1_data)
    );

    // ----------------------------------------------------------------
    // next values
    // ----------------------------------------------------------------
    wire [ims_pkg::PC_W-1:0] pc_inc = pc_q + 15'h0001;
    wire [ims_pkg::FSR_W-1:0] fsr_after = dec.op == ims_pkg::OP_STWI_K ? fsr_sel_v
        : fsr_stepped;

    assign state_d = wa_instr ? ims_pkg::ST_EXEC
        : do_pop ? ims_pkg::ST_HOLD
        : ims_pkg::ST_IDLE;

    assign w_d = do_sreset ? ims_pkg::RST_W
        : exec && dec.op == ims_pkg::OP_RETK ? dec.literal
        : wa_wreg ? w_data_q[7:0] : w_q;

    assign fsr0_d = do_sreset ? ims_pkg::RST_FSR
        : do_store && !dec.fsr_sel ? fsr_after
        : wa_fsr0 ? w_data_q[ims_pkg::FSR_W-1:0] : fsr0_q;

    assign fsr1_d = do_sreset ? ims_pkg::RST_FSR
        : do_store && dec.fsr_sel ? fsr_after
        : wa_fsr1 ? w_data_q[ims_pkg::FSR_W-1:0] : fsr1_q;

    assign pc_d = do_sreset ? ims_pkg::RST_PC
        : do_pop ? stk_q[sp_top]
        : exec ? pc_inc
        : wa_pc ? w_data_q[ims_pkg::PC_W-1:0] : pc_q;

    assign ien_d = do_sreset ? ims_pkg::RST_IEN
        : exec && dec.op == ims_pkg::OP_RETI ? 1'b1
        : wa_ictl ? w_data_q[ims_pkg::IEN_BIT] : ien_q;

    // software may only set the flag; the reset instruction clears it
    assign swrf_d = do_sreset ? 1'b0
        : wa_pctl && w_data_q[ims_pkg::SWRF_BIT] ? 1'b1 : swrf_q;

    wire pop_ok = do_pop && cnt_q != 5'h00;
    wire push_ok = wa_stack && cnt_q != 5'h10;
    assign sp_d = do_sreset ? 4'h0
        : pop_ok ? sp_top
        : wa_stack ? sp_q + 4'h1 : sp_q;
    assign cnt_d = do_sreset ? 5'h00
        : pop_ok ? cnt_q - 5'h01
        : push_ok ? cnt_q + 5'h01 : cnt_q;

    // ----------------------------------------------------------------
    // registers
    // ----------------------------------------------------------------
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            state_q <= ims_pkg::ST_IDLE;
            ins_q <= ims_pkg::OPC_NOP;
            w_q <= ims_pkg::RST_W;
            fsr0_q <= ims_pkg::RST_FSR;
            fsr1_q <= ims_pkg::RST_FSR;
            pc_q <= ims_pkg::RST_PC;
            ien_q <= ims_pkg::RST_IEN;
            swrf_q <= ims_pkg::RST_SWRF;
            sp_q <= 4'h0;
            cnt_q <= 5'h00;
            rst_req_q <= 1'b0;
        end else begin
            state_q <= state_d;
            if (wa_instr) begin
                ins_q <= w_data_q[ims_pkg::INSTR_W-1:0];
            end
            w_q <= w_d;
            fsr0_q <= fsr0_d;
            fsr1_q <= fsr1_d;
            pc_q <= pc_d;
            ien_q <= ien_d;
            swrf_q <= swrf_d;
            sp_q <= sp_d;
            cnt_q <= cnt_d;
            rst_req_q <= do_sreset;
        end
    end

    // the stack wraps like a ring on pushes; the count tracks how many entries are live and stops a pop from moving the pointer when it is zero
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            for (int i = 0; i < ims_pkg::STK_DEPTH; i++) begin
                stk_q[i] <= ims_pkg::RST_PC;
            end
        end else if (wa_stack) begin
            stk_q[sp_q] <= w_data_q[ims_pkg::PC_W-1:0];
        end
    end

    // ----------------------------------------------------------------
    // axi4-lite read side
    // ----------------------------------------------------------------
    logic rvalid_q;
    logic [31:0] rdata_q;
    logic [1:0] rresp_q;
    logic [31:0] rd_mux;
    logic rd_hit;

    assign s_axi_arready = !rvalid_q;
    assign s_axi_rvalid = rvalid_q;
    assign s_axi_rdata = rdata_q;
    assign s_axi_rresp = rresp_q;

    wire [31:0] stat_word = {11'h0, cnt_q, 4'h0, sp_q, 7'h00, busy};

    always_comb begin
        rd_mux = 32'h0000_0000;
        rd_hit = 1'b1;
        unique case (s_axi_araddr)
            ims_pkg::OFF_INSTR: rd_mux = {18'h0, ins_q};
            ims_pkg::OFF_STAT: rd_mux = stat_word;
            ims_pkg::OFF_WREG: rd_mux = {24'h000000, w_q};
            ims_pkg::OFF_FSR0: rd_mux = {16'h0000, fsr0_q};
            ims_pkg::OFF_FSR1: rd_mux = {16'h0000, fsr1_q};
            ims_pkg::OFF_PC: rd_mux = {17'h0, pc_q};
            ims_pkg::OFF_ICTL: rd_mux = {24'h000000, ien_q, 7'h00};
            ims_pkg::OFF_PCTL: rd_mux = {29'h0, swrf_q, 2'h0};
            ims_pkg::OFF_STACK: rd_mux = {17'h0, stk_q[sp_top]};
            ims_pkg::OFF_INDF0: rd_mux = {24'h000000, indf0_data};
            ims_pkg::OFF_INDF1: rd_mux = {24'h000000, indf1_data};
            default: rd_hit = 1'b0;
        endcase
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            rvalid_q <= 1'b0;
            rdata_q <= 32'h0000_0000;
            rresp_q <= ims_pkg::RESP_OKAY;
        end else if (s_axi_arvalid && !rvalid_q) begin
            rvalid_q <= 1'b1;
            rdata_q <= rd_mux;
            rresp_q <= rd_hit ? ims_pkg::RESP_OKAY : ims_pkg::RESP_SLVERR;
        end else if (s_axi_rready) begin
            rvalid_q <= 1'b0;
        end
    end

    // ----------------------------------------------------------------
    // outputs
    // ----------------------------------------------------------------
    assign busy = state_q != ims_pkg::ST_IDLE;
    assign global_interrupt_enable = ien_q;
    assign device_reset_req = rst_req_q;

endmodule

/* ims_exec_chk.sv */
// bus and execution timing checks for the indirect move and return unit
module ims_exec_chk (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic [1:0] s_axi_bresp,
    input wire logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic s_axi_arvalid,
    input wire logic s_axi_arready,
    input wire logic [31:0] s_axi_rdata,
    input wire logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic device_reset_req,
    input wire logic global_interrupt_enable,
    input wire logic busy
);
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!rst_n);
    // ----------------------------------------------------------------
    // assertions
    // ----------------------------------------------------------------
    chk_b_hold: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
        else $error("write response dropped early");
    chk_r_hold: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
        else $error("read data dropped early");
    chk_rst_idle: assert property (device_reset_req |-> !busy)
        else $error("unit still busy during reset request");
    chk_rd_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
        else $error("read not answered next cycle");
    chk_resp_legal: assert property (s_axi_bvalid |-> s_axi_bresp inside {2'b00, 2'b10})
        else $error("illegal write response");
    chk_rst_pulse: assert property ($rose(device_reset_req) |=> !device_reset_req)
        else $error("reset request not one cycle");
    chk_rst_cause: assert property ($rose(device_reset_req) |-> $past(busy) && !global_interrupt_enable)
        else $error("reset request without executing reset");
    chk_busy_len: assert property ($rose(busy) |-> ##[1:2] !busy)
        else $error("instruction longer than two cycles");
    chk_ien_ret: assert property ($rose(global_interrupt_enable) && busy |=> !busy)
        else $error("return from interrupt timing wrong");
endmodule

bind ims_exec_unit ims_exec_chk ims_exec_chk_i (.clk(clk), .rst_n(rst_n),
    .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
    .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
    .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready), .busy(busy),
    .device_reset_req(device_reset_req), .global_interrupt_enable(global_interrupt_enable));

/* test_indirect_move_and_return_ops.sv */
// self-checking bench for the indirect move and return unit
module test_indirect_move_and_return_ops;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk = 1'b0, rst_n = 1'b0, awv = 1'b0, wv = 1'b0, bre = 1'b0, arv = 1'b0, rre = 1'b0;
    logic awr, wr_r, bv, arr, rv_o, drr, ien, busy, seen;
    logic [7:0] awa = 8'h00, ara = 8'h00;
    logic [31:0] wd = 32'h0, rdat, rv, p;
    logic [1:0] br, rr_o, rr;
    int errors = 0, n_checks = 0, bcyc = 0;
    always #2.5 clk = ~clk;
    always @(posedge clk) if (busy) bcyc <= bcyc + 1;
    always @(posedge clk) if (drr) seen <= 1'b1;
    ims_exec_unit ims_exec_unit_i (.clk(clk), .rst_n(rst_n), .s_axi_awaddr(awa),
        .s_axi_awvalid(awv), .s_axi_awready(awr), .s_axi_wdata(wd), .s_axi_wstrb(4'hf),
        .s_axi_wvalid(wv), .s_axi_wready(wr_r), .s_axi_bresp(br), .s_axi_bvalid(bv),
        .s_axi_bready(bre), .s_axi_araddr(ara), .s_axi_arvalid(arv), .s_axi_arready(arr),
        .s_axi_rdata(rdat), .s_axi_rresp(rr_o), .s_axi_rvalid(rv_o), .s_axi_rready(rre),
        .device_reset_req(drr), .global_interrupt_enable(ien), .busy(busy));
    // ----------------------------------------------------------------
    // bus tasks
    // ----------------------------------------------------------------
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_checks++;
        if (got !== exp) begin
            errors++;
            $display("[FAIL] t=%0t got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic ap, wp, bp;
        ap = 1; wp = 1; bp = 1;
        awa <= a; wd <= d; awv <= 1'b1; wv <= 1'b1; bre <= 1'b1;
        while (ap || wp || bp) begin
            @(posedge clk);
            if (ap && awr) begin ap = 0; awv <= 1'b0; end
            if (wp && wr_r) begin wp = 0; wv <= 1'b0; end
            if (bp && bv) begin bp = 0; bre <= 1'b0; rr = br; end
        end
        @(posedge clk);
    endtask
    task automatic rd(input logic [7:0] a);
        logic ap, rp;
        ap = 1; rp = 1;
        ara <= a; arv <= 1'b1; rre <= 1'b1;
        while (ap || rp) begin
            @(posedge clk);
            if (rp && rv_o) begin rp = 0; rre <= 1'b0; rv = rdat; rr = rr_o; end
            if (ap && arr) begin ap = 0; arv <= 1'b0; end
        end
        @(posedge clk);
    endtask
    task automatic rchk(input logic [7:0] a, input logic [31:0] exp);
        rd(a);
        chk(rv, exp);
    endtask
    // issue one instruction and count the cycles it keeps the unit busy
    task automatic exec(input logic [13:0] op, input int n);
        bcyc = 0;
        wr(ims_pkg::OFF_INSTR, {18'h0, op});
        for (int i = 0; i < 8 && busy !== 1'b0; i++) @(posedge clk);
        @(posedge clk);
        chk(32'(bcyc), 32'(n));
    endtask
    task automatic stop_test;
        if (errors == 0 && n_checks > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask
    // ----------------------------------------------------------------
    // tests
    // ----------------------------------------------------------------
    initial begin
        #100us;
        errors++;
        stop_test();
    end
    initial begin
        repeat (20) @(posedge clk);
        rst_n <= 1'b1;
        @(posedge clk);
        rchk(ims_pkg::OFF_WREG, 32'h0);
        rchk(ims_pkg::OFF_FSR0, 32'h0);
        rchk(ims_pkg::OFF_ICTL, 32'h0);
        rd(ims_pkg::OFF_PCTL);
        chk(rv & 32'h4, 32'h4);
        rd(8'h40);
        chk({30'h0, rr}, {30'h0, ims_pkg::RESP_SLVERR});
        wr(8'h40, 32'h1);
        chk({30'h0, rr}, {30'h0, ims_pkg::RESP_SLVERR});
        for (int m = 0; m < 4; m++) begin
            wr(ims_pkg::OFF_FSR0, 32'h10);
            wr(ims_pkg::OFF_WREG, 32'ha0 + 32'(m));
            exec(ims_pkg::OPC_STWI | 14'(m), 1);
            rchk(ims_pkg::OFF_FSR0, m[0] ? 32'h0f : 32'h11);
            wr(ims_pkg::OFF_FSR0, m == 0 ? 32'h11 : m == 1 ? 32'h0f : 32'h10);
            rchk(ims_pkg::OFF_INDF0, 32'ha0 + 32'(m));
        end
        wr(ims_pkg::OFF_FSR1, 32'h08);
        wr(ims_pkg::OFF_WREG, 32'h5c);
        exec(ims_pkg::OPC_STWI_K | 14'h007d, 1);
        rchk(ims_pkg::OFF_FSR1, 32'h08);
        wr(ims_pkg::OFF_FSR1, 32'h05);
        rchk(ims_pkg::OFF_INDF1, 32'h5c);
        wr(ims_pkg::OFF_INDF1, 32'h77);
        rchk(ims_pkg::OFF_INDF1, 32'h77);
        rchk(ims_pkg::OFF_FSR1, 32'h05);
        rd(ims_pkg::OFF_PC);
        p = rv;
        exec(ims_pkg::OPC_NOP, 1);
        rchk(ims_pkg::OFF_PC, p + 32'h1);
        rchk(ims_pkg::OFF_WREG, 32'h5c);
        wr(ims_pkg::OFF_STACK, 32'h1234);
        exec(ims_pkg::OPC_RETK | 14'h00ff, 2);
        rchk(ims_pkg::OFF_WREG, 32'hff);
        rchk(ims_pkg::OFF_PC, 32'h1234);
        wr(ims_pkg::OFF_STACK, 32'h0345);
        exec(ims_pkg::OPC_RETI, 2);
        chk({31'h0, ien}, 32'h1);
        rchk(ims_pkg::OFF_ICTL, 32'h80);
        rchk(ims_pkg::OFF_PC, 32'h0345);
        seen = 1'b0;
        exec(ims_pkg::OPC_RESET, 1);
        chk({31'h0, seen}, 32'h1);
        chk({31'h0, ien}, 32'h0);
        rchk(ims_pkg::OFF_WREG, 32'h0);
        rd(ims_pkg::OFF_PCTL);
        chk(rv & 32'h4, 32'h0);
        stop_test();
    end
endmodule
